/* File: core/perf_event_select_pkg.sv */
`default_nettype none
package perf_event_select_pkg;
    // Event numbers
    localparam logic [7:0] EV_MEM_LOAD = 8'hcb;
    localparam logic [7:0] EV_FP_SIMD = 8'hcc;
    localparam logic [7:0] EV_DECODED = 8'hd0;
    localparam logic [7:0] EV_UOPS_DEC = 8'hd1;
    localparam logic [7:0] EV_FLAG_STALL = 8'hd2;
    // Unit masks
    localparam logic [7:0] UM_FILL_BUFFER_HIT = 8'h40;
    localparam logic [7:0] UM_XLATE_MISS = 8'h80;
    localparam logic [7:0] UM_TO_FLOAT = 8'h01;
    localparam logic [7:0] UM_TO_SIMD = 8'h02;
    localparam logic [7:0] UM_ANY_TRANS = 8'h03;
    localparam logic [7:0] UM_INSTS = 8'h01;
    localparam logic [7:0] UM_STALL = 8'h01;
    localparam logic [7:0] UM_SEQ = 8'h02;
    localparam logic [7:0] UM_SP_FOLD = 8'h04;
    localparam logic [7:0] UM_SP_SYNC = 8'h08;
    localparam logic [7:0] UM_FLAGS = 8'h01;
    // Uop count above which the sequencer delivers
    localparam logic [3:0] SEQ_UOP_LIMIT = 4'h4;

    typedef enum logic {
        MODE_FLOAT,
        MODE_SIMD
    } exec_mode_t;

    typedef struct packed {
        logic load_retired;
        logic load_l1_miss;
        logic load_fill_buffer;
        logic load_xlate_miss;
        logic load_fault;
        logic load_cacheable;
        logic load_sw_prefetch;
    } load_info_t;

    typedef struct packed {
        logic float_inst;
        logic simd_inst;
        logic [2:0] insts_decoded;
        logic decode_active;
        logic [2:0] seq_uops;
        logic [3:0] inst_uop_len;
        logic assist;
        logic [2:0] sp_fold_insts;
        logic sp_sync;
        logic flag_stall;
    } core_events_t;

    typedef struct packed {
        logic [7:0] event_code;
        logic [7:0] unit_mask;
    } event_select_t;
endpackage
`default_nettype wire

/* File: core/perf_event_select_decoder.sv */
// Function
// R1 - CBH/40H counts retired loads hitting fill buffer
// R2 - CBH/80H counts retired loads missing translation buffer
// R3 - Faulting loads excluded from translation miss count
// R4 - Only cacheable, non-prefetch loads count translation misses
// R5 - CCH/01H counts first float after simd
// R6 - CCH/02H counts first simd after float
// R7 - CCH/03H counts transitions both directions
// R8 - D0H/01H counts decoded instructions
// R9 - D1H/01H counts decoder stall cycles, inverted
// R10 - D1H/02H counts microcode sequencer uops
// R11 - D1H/04H counts folded stack-pointer instructions
// R12 - D1H/08H counts stack-pointer sync operations
// R13 - D2H/01H counts flag stall cycles
// R14 - Unlisted code/mask pairs give no increment
`default_nettype none
module perf_event_select_decoder
    import perf_event_select_pkg::*;
#(
    parameter int INC_W = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Selection from counter configuration
    input wire event_select_t sel,
    // Event sources from the pipeline
    input wire load_info_t load,
    input wire core_events_t ev,
    // Increment to the counter
    output logic [INC_W-1:0] increment,
    output logic event_hit
);

    // ============================================================
    // Float/simd state tracking
    exec_mode_t mode_q, mode_d;
    logic to_float, to_simd;

    always_comb begin
        mode_d = mode_q;
        to_float = 1'b0;
        to_simd = 1'b0;
        // Float wins if both arrive together: no single cycle mixes states
        if (ev.float_inst && mode_q == MODE_SIMD) begin
            to_float = 1'b1; // see R5
            mode_d = MODE_FLOAT;
        end else if (ev.simd_inst && !ev.float_inst && mode_q == MODE_FLOAT) begin
            to_simd = 1'b1; // see R6
            mode_d = MODE_SIMD;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q <= MODE_FLOAT;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ============================================================
    // Event selection
    logic [INC_W-1:0] inc_d, inc_q;
    logic hit_d, hit_q;
    logic xlate_ok, seq_active;

    always_comb begin
        // see R3 see R4
        xlate_ok = load.load_retired && load.load_xlate_miss && !load.load_fault &&
                   load.load_cacheable && !load.load_sw_prefetch;
        // Sequencer only supplies uops for long instructions or assists
        seq_active = (ev.inst_uop_len > SEQ_UOP_LIMIT) || ev.assist; // see R10
        inc_d = '0;
        case (sel.event_code)
            EV_MEM_LOAD: begin
                if (sel.unit_mask == UM_FILL_BUFFER_HIT) begin
                    inc_d = INC_W'(load.load_retired && load.load_l1_miss &&
                                   load.load_fill_buffer); // see R1
                end else if (sel.unit_mask == UM_XLATE_MISS) begin
                    inc_d = INC_W'(xlate_ok); // see R2
                end
            end
            EV_FP_SIMD: begin
                if (sel.unit_mask == UM_TO_FLOAT) begin
                    inc_d = INC_W'(to_float); // see R5
                end else if (sel.unit_mask == UM_TO_SIMD) begin
                    inc_d = INC_W'(to_simd); // see R6
                end else if (sel.unit_mask == UM_ANY_TRANS) begin
                    inc_d = INC_W'(to_float | to_simd); // see R7
                end
            end
            EV_DECODED: begin
                if (sel.unit_mask == UM_INSTS) begin
                    inc_d = INC_W'(ev.insts_decoded); // see R8
                end
            end
            EV_UOPS_DEC: begin
                if (sel.unit_mask == UM_STALL) begin
                    // Inverted compare: count cycles with nothing decoded
                    inc_d = INC_W'(!ev.decode_active); // see R9
                end else if (sel.unit_mask == UM_SEQ) begin
                    inc_d = seq_active ? INC_W'(ev.seq_uops) : '0; // see R10
                end else if (sel.unit_mask == UM_SP_FOLD) begin
                    inc_d = INC_W'(ev.sp_fold_insts); // see R11
                end else if (sel.unit_mask == UM_SP_SYNC) begin
                    inc_d = INC_W'(ev.sp_sync); // see R12
                end
            end
            EV_FLAG_STALL: begin
                if (sel.unit_mask == UM_FLAGS) begin
                    inc_d = INC_W'(ev.flag_stall); // see R13
                end
            end
            default: begin
                inc_d = '0; // see R14
            end
        endcase
        hit_d = (inc_d != '0);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            inc_q <= '0;
            hit_q <= 1'b0;
        end else begin
            inc_q <= inc_d;
            hit_q <= hit_d;
        end
    end

    assign increment = inc_q;
    assign event_hit = hit_q;

    // ============================================================
    // Checks
    a_fill_hit: assert property (@(posedge clk) disable iff (srst) // see R1
        (sel.event_code == EV_MEM_LOAD && sel.unit_mask == UM_FILL_BUFFER_HIT &&
         load.load_retired && load.load_l1_miss && load.load_fill_buffer)
        |=> increment == INC_W'(1))
        else $error("fill buffer hit not counted");
    a_xlate_fault: assert property (@(posedge clk) disable iff (srst) // see R3
        (sel.event_code == EV_MEM_LOAD && sel.unit_mask == UM_XLATE_MISS && load.load_fault)
        |=> increment == '0)
        else $error("faulting load counted");
    a_xlate_prefetch: assert property (@(posedge clk) disable iff (srst) // see R4
        (sel.event_code == EV_MEM_LOAD && sel.unit_mask == UM_XLATE_MISS &&
         (load.load_sw_prefetch || !load.load_cacheable)) |=> increment == '0)
        else $error("prefetch or uncacheable load counted");
    a_xlate_miss: assert property (@(posedge clk) disable iff (srst) // see R2
        (sel.event_code == EV_MEM_LOAD && sel.unit_mask == UM_XLATE_MISS && xlate_ok)
        |=> event_hit)
        else $error("translation miss not counted");
    a_to_float_once: assert property (@(posedge clk) disable iff (srst) // see R5
        (sel.event_code == EV_FP_SIMD && sel.unit_mask == UM_TO_FLOAT &&
         ev.float_inst && !ev.simd_inst)[*2] |=> increment == '0)
        else $error("second float instruction counted");
    a_to_simd: assert property (@(posedge clk) disable iff (srst) // see R6
        (sel.event_code == EV_FP_SIMD && sel.unit_mask == UM_TO_SIMD &&
         mode_q == MODE_FLOAT && ev.simd_inst && !ev.float_inst) |=> event_hit)
        else $error("float to simd transition missed");
    a_any_trans: assert property (@(posedge clk) disable iff (srst) // see R7
        (sel.event_code == EV_FP_SIMD && sel.unit_mask == UM_ANY_TRANS)
        |=> event_hit == ($past(mode_q) != mode_q))
        else $error("transition count mismatch");
    a_decoded: assert property (@(posedge clk) disable iff (srst) // see R8
        (sel.event_code == EV_DECODED && sel.unit_mask == UM_INSTS)
        |=> increment == INC_W'($past(ev.insts_decoded)))
        else $error("decoded count wrong");
    a_stall_inv: assert property (@(posedge clk) disable iff (srst) // see R9
        (sel.event_code == EV_UOPS_DEC && sel.unit_mask == UM_STALL)
        |=> event_hit == !$past(ev.decode_active))
        else $error("stall cycle not inverted");
    a_seq_gate: assert property (@(posedge clk) disable iff (srst) // see R10
        (sel.event_code == EV_UOPS_DEC && sel.unit_mask == UM_SEQ && !ev.assist &&
         ev.inst_uop_len <= SEQ_UOP_LIMIT) |=> increment == '0)
        else $error("sequencer uops counted for short instruction");
    a_sp_fold: assert property (@(posedge clk) disable iff (srst) // see R11
        (sel.event_code == EV_UOPS_DEC && sel.unit_mask == UM_SP_FOLD)
        |=> increment == INC_W'($past(ev.sp_fold_insts)))
        else $error("folding count wrong");
    a_sp_sync: assert property (@(posedge clk) disable iff (srst) // see R12
        (sel.event_code == EV_UOPS_DEC && sel.unit_mask == UM_SP_SYNC)
        |=> event_hit == $past(ev.sp_sync))
        else $error("sync count wrong");
    a_flag_stall: assert property (@(posedge clk) disable iff (srst) // see R13
        (sel.event_code == EV_FLAG_STALL && sel.unit_mask == UM_FLAGS)
        |=> event_hit == $past(ev.flag_stall))
        else $error("flag stall count wrong");
    a_unlisted: assert property (@(posedge clk) disable iff (srst) // see R14
        (sel.event_code == EV_FLAG_STALL && sel.unit_mask != UM_FLAGS) |=> !event_hit)
        else $error("unlisted pair counted");
    a_reset_quiet: assert property (@(posedge clk) // see R14
        srst |=> (increment == '0 && !event_hit))
        else $error("output not cleared by reset");
    a_reset_mode: assert property (@(posedge clk) // see R5
        srst |=> mode_q == MODE_FLOAT)
        else $error("mode not float after reset");
    a_fill_miss: assert property (@(posedge clk) disable iff (srst) // see R1
        (sel.event_code == EV_MEM_LOAD && sel.unit_mask == UM_FILL_BUFFER_HIT &&
         !(load.load_retired && load.load_l1_miss && load.load_fill_buffer))
        |=> increment == '0)
        else $error("fill buffer hit counted without a hit");
    a_to_float_first: assert property (@(posedge clk) disable iff (srst) // see R5
        (sel.event_code == EV_FP_SIMD && sel.unit_mask == UM_TO_FLOAT &&
         mode_q == MODE_SIMD && ev.float_inst) |=> increment == INC_W'(1))
        else $error("simd to float transition missed");
    a_seq_pass: assert property (@(posedge clk) disable iff (srst) // see R10
        (sel.event_code == EV_UOPS_DEC && sel.unit_mask == UM_SEQ &&
         (ev.inst_uop_len > SEQ_UOP_LIMIT || ev.assist))
        |=> increment == INC_W'($past(ev.seq_uops)))
        else $error("sequencer uops not passed");
    // Codes outside the table must never leak an increment, whatever the mask
    a_unknown_code: assert property (@(posedge clk) disable iff (srst) // see R14
        (sel.event_code != EV_MEM_LOAD && sel.event_code != EV_FP_SIMD &&
         sel.event_code != EV_DECODED && sel.event_code != EV_UOPS_DEC &&
         sel.event_code != EV_FLAG_STALL) |=> !event_hit)
        else $error("unknown event code counted");
    a_unlisted_mask: assert property (@(posedge clk) disable iff (srst) // see R14
        ((sel.event_code == EV_MEM_LOAD && sel.unit_mask != UM_FILL_BUFFER_HIT &&
          sel.unit_mask != UM_XLATE_MISS) ||
         (sel.event_code == EV_FP_SIMD && sel.unit_mask != UM_TO_FLOAT &&
          sel.unit_mask != UM_TO_SIMD && sel.unit_mask != UM_ANY_TRANS) ||
         (sel.event_code == EV_DECODED && sel.unit_mask != UM_INSTS) ||
         (sel.event_code == EV_UOPS_DEC && sel.unit_mask != UM_STALL &&
          sel.unit_mask != UM_SEQ && sel.unit_mask != UM_SP_FOLD &&
          sel.unit_mask != UM_SP_SYNC)) |=> !event_hit)
        else $error("unlisted mask counted");

endmodule
`default_nettype wire

/* File: test/core_event_source.sv */
`default_nettype none
// =====================================================
// Pipeline event source model
module core_event_source
    import perf_event_select_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Random word from the bench
    input wire logic [31:0] rnd,
    // Event pulses toward the decoder
    output load_info_t load,
    output core_events_t ev
);
    timeunit 1ns;
    timeprecision 1ps;

    // Fresh events every cycle; quiet in reset so no pulse predates the first sample
    always_ff @(posedge clk) begin
        load <= srst ? '0 : load_info_t'(rnd[6:0]);
        ev <= srst ? '0 : core_events_t'(rnd[25:7]);
    end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
module tb;
    import perf_event_select_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] seed = 32'hd4d5;
    logic [31:0] rnd = '0;
    event_select_t sel = '0;
    load_info_t load;
    core_events_t ev;
    logic [2:0] increment;
    logic event_hit;
    exec_mode_t mode = MODE_FLOAT;
    logic [3:0] notes[$];
    logic [3:0] want;
    logic [2:0] exp_v;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    // Last entry is outside the supported set and must stay silent
    logic [15:0] pairs[12] = '{{EV_MEM_LOAD, UM_FILL_BUFFER_HIT}, {EV_MEM_LOAD, UM_XLATE_MISS},
        {EV_FP_SIMD, UM_TO_FLOAT}, {EV_FP_SIMD, UM_TO_SIMD}, {EV_FP_SIMD, UM_ANY_TRANS},
        {EV_DECODED, UM_INSTS}, {EV_UOPS_DEC, UM_STALL}, {EV_UOPS_DEC, UM_SEQ},
        {EV_UOPS_DEC, UM_SP_FOLD}, {EV_UOPS_DEC, UM_SP_SYNC}, {EV_FLAG_STALL, UM_FLAGS},
        {EV_FLAG_STALL, UM_SP_FOLD}};

    // =====================================================
    // Design and event source
    perf_event_select_decoder #(.INC_W(3)) perf_event_select_decoder_inst (.clk(clk),
        .srst(srst), .sel(sel), .load(load), .ev(ev), .increment(increment),
        .event_hit(event_hit));
    core_event_source core_event_source_inst (.clk(clk), .srst(srst), .rnd(rnd),
        .load(load), .ev(ev));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [2:0] exp_inc(event_select_t s, load_info_t l, core_events_t e,
        exec_mode_t m);
        case ({s.event_code, s.unit_mask})
            {EV_MEM_LOAD, UM_FILL_BUFFER_HIT}: return {2'b0, l.load_retired & l.load_l1_miss &
                l.load_fill_buffer};
            {EV_MEM_LOAD, UM_XLATE_MISS}: return {2'b0, l.load_retired & l.load_xlate_miss &
                ~l.load_fault & l.load_cacheable & ~l.load_sw_prefetch};
            {EV_FP_SIMD, UM_TO_FLOAT}: return {2'b0, e.float_inst & (m == MODE_SIMD)};
            {EV_FP_SIMD, UM_TO_SIMD}: return {2'b0, e.simd_inst & ~e.float_inst &
                (m == MODE_FLOAT)};
            {EV_FP_SIMD, UM_ANY_TRANS}: return {2'b0, (e.float_inst & (m == MODE_SIMD)) |
                (e.simd_inst & ~e.float_inst & (m == MODE_FLOAT))};
            {EV_DECODED, UM_INSTS}: return e.insts_decoded;
            {EV_UOPS_DEC, UM_STALL}: return {2'b0, ~e.decode_active};
            {EV_UOPS_DEC, UM_SEQ}: return (e.inst_uop_len > SEQ_UOP_LIMIT || e.assist) ?
                e.seq_uops : 3'h0;
            {EV_UOPS_DEC, UM_SP_FOLD}: return e.sp_fold_insts;
            {EV_UOPS_DEC, UM_SP_SYNC}: return {2'b0, e.sp_sync};
            {EV_FLAG_STALL, UM_FLAGS}: return {2'b0, e.flag_stall};
            default: return 3'h0;
        endcase
    endfunction

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // =====================================================
    // Stimulus
    always #12.5 clk = ~clk;

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4000) begin
            @(posedge clk);
            seed = xs(seed);
            rnd <= seed;
            // Mix listed pairs, listed codes with stray masks, and fully random selections
            if (seed[31:28] < 4'hc) begin
                sel <= pairs[seed[31:28]];
            end else if (seed[31:28] < 4'hf) begin
                sel <= {pairs[seed[27:24] % 12][15:8], seed[7:0]};
            end else begin
                sel <= seed[15:0];
            end
        end
        repeat (3) @(posedge clk);
        print_verdict();
    end

    // Note the answer for what the design will sample at the next edge
    always @(negedge clk) begin
        if (srst) begin
            mode = MODE_FLOAT;
        end else begin
            exp_v = exp_inc(sel, load, ev, mode);
            notes.push_back({exp_v != 3'h0, exp_v});
            if (ev.float_inst) mode = MODE_FLOAT;
            else if (ev.simd_inst) mode = MODE_SIMD;
        end
    end

    // =====================================================
    // Output watcher
    always @(posedge clk) begin
        #1;
        if (notes.size() > 0) begin
            want = notes.pop_front();
            n_compared++;
            if ({event_hit, increment} !== want) begin
                err_count++;
                $display("wrong value at %0t: expected %h got %h", $time, want,
                    {event_hit, increment});
            end
        end
    end

    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            print_verdict();
        end
    end
endmodule
`default_nettype wire
